// file: inc/mdmac_pkg.sv
// Constants and carrier types of the multiply/divide/MAC coprocessor
package mdmac_pkg;
  // Mode value layout
  localparam int unsigned MODE_W     = 7;
  localparam int unsigned OUT_MSB    = 6;
  localparam int unsigned OUT_LSB    = 4;
  localparam int unsigned OPC_MSB    = 3;
  localparam int unsigned OPC_LSB    = 0;
  localparam logic [6:0]  MODE_RST   = 7'h00;
  localparam logic [31:0] RES_RST    = 32'h0000_0000;
  localparam logic [3:0]  FLAGS_CLR  = 4'h0;
  // Carry, overflow, zero, negative: only overflow is ever raised
  localparam logic [3:0]  FLAGS_OVF  = 4'h4;
  // Operation codes
  localparam logic [3:0]  OPC_CLR    = 4'h0;
  localparam logic [3:0]  OPC_LD16   = 4'h1;
  localparam logic [3:0]  OPC_LD32_0 = 4'h2;
  localparam logic [3:0]  OPC_READ   = 4'h3;
  localparam logic [3:0]  OPC_MULU   = 4'h4;
  localparam logic [3:0]  OPC_MULS   = 4'h5;
  localparam logic [3:0]  OPC_MACU   = 4'h6;
  localparam logic [3:0]  OPC_MACS   = 4'h7;
  localparam logic [3:0]  OPC_DIVU   = 4'h8;
  localparam logic [3:0]  OPC_DIVS   = 4'h9;
  localparam logic [3:0]  OPC_LD32_1 = 4'ha;
  // Output half codes
  localparam logic [2:0]  OUT_R0_LO  = 3'h0;
  localparam logic [2:0]  OUT_R0_HI  = 3'h1;
  localparam logic [2:0]  OUT_R1_LO  = 3'h2;
  localparam logic [2:0]  OUT_R1_HI  = 3'h3;
  // Division: two quotient bits per cycle, sixteen iteration cycles
  localparam logic [3:0]  DIV_LAST   = 4'hf;
  localparam logic [3:0]  DIV_FIRST  = 4'h0;

  // Request from the core, one instruction at most per cycle
  typedef struct packed {
    logic        mode_wr;
    logic        load;
    logic        op;
    logic [6:0]  mode_data;
    logic [15:0] opa;
    logic [15:0] opb;
  } mdmac_req_t;

  // Answer to the core
  typedef struct packed {
    logic [15:0] data;
    logic [3:0]  flags;
  } mdmac_rsp_t;

  typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_FIX} mdmac_state_t;
endpackage

// file: rtl/mdmac_coproc.sv
// Multiply, multiply-accumulate and divide coprocessor datapath
`timescale 1ns/100ps
module mdmac_coproc
  import mdmac_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // Core instruction side
  input  wire mdmac_req_t req_i,
  output logic            busy_o,
  output logic            done_o,
  output mdmac_rsp_t      rsp_o
);

  function automatic logic [31:0] mul16(input logic [15:0] a,
                                        input logic [15:0] b,
                                        input logic        sgn);
    logic [31:0] ea;
    logic [31:0] eb;
    ea = sgn ? {{16{a[15]}}, a} : {16'h0000, a};
    eb = sgn ? {{16{b[15]}}, b} : {16'h0000, b};
    return 32'(ea * eb);
  endfunction

  // One restoring step on the packed partial remainder and dividend
  function automatic logic [63:0] div_step(input logic [63:0] rq,
                                           input logic [31:0] d);
    logic [32:0] t;
    logic [32:0] diff;
    t    = rq[63:31];
    diff = t - {1'b0, d};
    if (t >= {1'b0, d}) begin
      return {diff[31:0], rq[30:0], 1'b1};
    end
    return {t[31:0], rq[30:0], 1'b0};
  endfunction

  function automatic logic [15:0] pick_half(input logic [2:0]  sel,
                                            input logic [31:0] r0,
                                            input logic [31:0] r1);
    case (sel)
      OUT_R0_LO: return r0[15:0];
      OUT_R0_HI: return r0[31:16];
      OUT_R1_LO: return r1[15:0];
      OUT_R1_HI: return r1[31:16];
      // Reserved codes read as zero
      default:   return 16'h0000;
    endcase
  endfunction

  function automatic logic [31:0] neg_if(input logic [31:0] v,
                                         input logic        n);
    return n ? 32'(-v) : v;
  endfunction

  mdmac_state_t state;
  mdmac_state_t next_state;
  logic [6:0]   mode;
  logic [6:0]   next_mode;
  logic [31:0]  result_reg_zero;
  logic [31:0]  next_result_reg_zero;
  logic [31:0]  result_reg_one;
  logic [31:0]  next_result_reg_one;
  logic [3:0]   flags;
  logic [3:0]   next_flags;
  logic [15:0]  data;
  logic [15:0]  next_data;
  logic         done;
  logic         next_done;
  logic [63:0]  rq;
  logic [63:0]  next_rq;
  logic [31:0]  dvs;
  logic [31:0]  next_dvs;
  logic [3:0]   cnt;
  logic [3:0]   next_cnt;
  logic         q_neg;
  logic         next_q_neg;
  logic         r_neg;
  logic         next_r_neg;

  logic [3:0]   opc;
  logic [2:0]   osel;
  logic         idle;
  logic [31:0]  prod;
  logic [31:0]  acc;
  logic [31:0]  dvs_in;
  logic         sgn;

  assign opc    = mode[OPC_MSB:OPC_LSB];
  assign osel   = mode[OUT_MSB:OUT_LSB];
  assign idle   = (state == ST_IDLE);
  assign sgn    = opc[0];
  assign prod   = mul16(req_i.opa, req_i.opb, sgn);
  assign acc    = 32'(result_reg_zero + prod);
  assign dvs_in = {req_i.opa, req_i.opb};

  assign busy_o = !idle;
  assign done_o = done;
  assign rsp_o  = '{data: data, flags: flags};

  always_comb begin
    next_state = state;
    next_mode  = mode;
    next_result_reg_zero  = result_reg_zero;
    next_result_reg_one  = result_reg_one;
    next_flags = flags;
    next_data  = data;
    next_done  = 1'b0;
    next_rq    = rq;
    next_dvs   = dvs;
    next_cnt   = cnt;
    next_q_neg = q_neg;
    next_r_neg = r_neg;
    case (state)
      ST_IDLE: begin
        if (req_i.mode_wr) begin
          next_mode = req_i.mode_data;
          if (req_i.mode_data[OPC_MSB:OPC_LSB] == OPC_CLR) begin
            next_result_reg_zero = RES_RST;
            next_result_reg_one = RES_RST;
          end
        end else if (req_i.load) begin
          // load clears flags, except in read mode
          if (opc != OPC_READ) begin
            next_flags = FLAGS_CLR;
          end
          case (opc)
            OPC_LD16:   next_result_reg_zero = {16'h0000, req_i.opb};
            OPC_LD32_0: next_result_reg_zero = dvs_in;
            OPC_LD32_1: next_result_reg_one = dvs_in;
            default:    next_result_reg_zero = result_reg_zero;
          endcase
        end else if (req_i.op) begin
          next_done  = 1'b1;
          next_flags = FLAGS_CLR;
          next_data  = pick_half(osel, result_reg_zero, result_reg_one);
          case (opc)
            // read leaves registers and flags alone
            OPC_READ: next_flags = flags;
            OPC_MULU, OPC_MULS: begin
              next_result_reg_zero = prod;
              next_data = pick_half(osel, prod, result_reg_one);
            end
            OPC_MACU, OPC_MACS: begin
              next_result_reg_zero = acc;
              next_data = pick_half(osel, acc, result_reg_one);
              if (sgn && (prod[31] == result_reg_zero[31]) && (acc[31] != prod[31])) begin
                next_flags = FLAGS_OVF;
              end
            end
            // start division; divisor zero is not guarded
            OPC_DIVU, OPC_DIVS: begin
              next_done  = 1'b0;
              next_state = ST_DIV;
              next_cnt   = DIV_FIRST;
              next_q_neg = sgn && (result_reg_zero[31] ^ dvs_in[31]);
              next_r_neg = sgn && result_reg_zero[31];
              next_rq    = {32'h0000_0000, neg_if(result_reg_zero, sgn && result_reg_zero[31])};
              next_dvs   = neg_if(dvs_in, sgn && dvs_in[31]);
            end
            default:  next_result_reg_zero = result_reg_zero;
          endcase
        end
      end
      ST_DIV: begin
        // Two bits per cycle keeps the latency inside the window
        next_rq  = div_step(div_step(rq, dvs), dvs);
        next_cnt = 4'(cnt + 4'h1);
        if (cnt == DIV_LAST) begin
          next_state = ST_FIX;
        end
      end
      ST_FIX: begin
        // sign fix, write back, select half
        next_result_reg_zero  = neg_if(rq[31:0], q_neg);
        next_result_reg_one  = neg_if(rq[63:32], r_neg);
        next_data  = pick_half(osel, next_result_reg_zero, next_result_reg_one);
        next_flags = FLAGS_CLR;
        next_done  = 1'b1;
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
      mode  <= MODE_RST;
      result_reg_zero  <= RES_RST;
      result_reg_one  <= RES_RST;
      flags <= FLAGS_CLR;
      data  <= 16'h0000;
      done  <= 1'b0;
      rq    <= 64'h0000_0000_0000_0000;
      dvs   <= RES_RST;
      cnt   <= DIV_FIRST;
      q_neg <= 1'b0;
      r_neg <= 1'b0;
    end else begin
      state <= next_state;
      mode  <= next_mode;
      result_reg_zero  <= next_result_reg_zero;
      result_reg_one  <= next_result_reg_one;
      flags <= next_flags;
      data  <= next_data;
      done  <= next_done;
      rq    <= next_rq;
      dvs   <= next_dvs;
      cnt   <= next_cnt;
      q_neg <= next_q_neg;
      r_neg <= next_r_neg;
    end
  end

  sequence op_go(logic [3:0] code);
    idle && req_i.op && !req_i.mode_wr && !req_i.load && opc == code;
  endsequence

  sequence div_go;
    idle && req_i.op && !req_i.mode_wr && !req_i.load && opc[3:1] == 3'h4;
  endsequence

  mode_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    idle && req_i.mode_wr |=> mode == $past(req_i.mode_data))
    else $error("mode value not taken");
  init_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    idle && req_i.mode_wr && req_i.mode_data[3:0] == OPC_CLR
    |=> result_reg_zero == RES_RST && result_reg_one == RES_RST)
    else $error("clear mode did not clear");
  load_low_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    idle && req_i.load && !req_i.mode_wr && opc == OPC_LD16
    |=> result_reg_zero == {16'h0000, $past(req_i.opb)})
    else $error("16-bit load wrong");
  mul_one_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    op_go(OPC_MULU) |=> done_o && flags == FLAGS_CLR
    && result_reg_zero == {16'h0000, $past(req_i.opa)}
               * {16'h0000, $past(req_i.opb)})
    else $error("unsigned multiply wrong");
  read_keep_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    op_go(OPC_READ) |=> $stable(result_reg_zero) && $stable(result_reg_one) && done_o)
    else $error("read mode altered results");
  div_time_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    div_go |=> busy_o [*8] ##[9:12] (done_o && !busy_o))
    else $error("division latency out of range");
  macu_flag_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    op_go(OPC_MACU) |=> flags == FLAGS_CLR && result_reg_zero == $past(acc))
    else $error("unsigned accumulate flagged");
  out_sel_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    done_o && osel == OUT_R1_HI |-> rsp_o.data == result_reg_one[31:16])
    else $error("output half mismatch");
  rsvd_keep_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    idle && req_i.op && !req_i.mode_wr && !req_i.load && opc > OPC_LD32_1
    |=> $stable(result_reg_zero) && $stable(result_reg_one))
    else $error("reserved op changed results");
endmodule

// file: verification/mdmac_core_model.sv
// Core model issuing coprocessor instructions
`timescale 1ns/100ps
module mdmac_core_model
  import mdmac_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Coprocessor answer
  input  wire logic       busy_i,
  input  wire logic       done_i,
  input  wire mdmac_rsp_t rsp_i,
  // Instruction request
  output mdmac_req_t      req_o
);
  initial req_o = '0;

  // Released lines show inverted junk, not the last value
  task automatic issue(input logic [2:0] k, input logic [6:0] m,
                       input logic [15:0] a, input logic [15:0] b);
    @(posedge clk_i);
    req_o <= {k, m, a, b};
    @(posedge clk_i);
    req_o <= {3'b000, ~req_o[38:0]};
  endtask

  task automatic put_mode(input logic [6:0] m);
    issue(3'b100, m, 16'hffff, 16'h0000);
  endtask

  task automatic put_load(input logic [15:0] a, input logic [15:0] b);
    issue(3'b010, 7'h7f, a, b);
  endtask

  task automatic put_op(input logic [15:0] a, input logic [15:0] b,
                        output logic [15:0] d, output logic [3:0] f,
                        output int cyc, output int bcnt);
    issue(3'b001, 7'h7f, a, b);
    cyc  = 0;
    bcnt = 0;
    do begin
      @(negedge clk_i);
      cyc++;
      if (busy_i === 1'b1) bcnt++;
    end while (done_i !== 1'b1 && cyc < 40);
    d = rsp_i.data;
    f = rsp_i.flags;
  endtask
endmodule

// file: verification/mdmac_coproc_tb.sv
// Self-checking bench of the coprocessor
`timescale 1ns/100ps
module mdmac_coproc_tb;
  import mdmac_pkg::*;
  typedef struct packed {
    logic [1:0]  kind;
    logic [6:0]  mode;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] d;
    logic [3:0]  f;
  } mdmac_row_t;

  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        busy_o;
  logic        done_o;
  mdmac_req_t  req_i;
  mdmac_rsp_t  rsp_o;
  int          fails = 0;
  int          tests_run = 0;
  logic [15:0] d;
  logic [3:0]  f;
  int          cyc;
  int          bcnt;
  mdmac_row_t  rows [29];

  always #25 clk_i = ~clk_i;

  mdmac_coproc u_dut (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .req_i  (req_i),
    .busy_o (busy_o),
    .done_o (done_o),
    .rsp_o  (rsp_o)
  );

  mdmac_core_model u_core (
    .clk_i  (clk_i),
    .busy_i (busy_o),
    .done_i (done_o),
    .rsp_i  (rsp_o),
    .req_o  (req_i)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Kind 0 operate, 1 load, 2 mode only
  initial begin
    rows = '{
      {2'd0, 7'h04, 16'hffff, 16'h0002, 16'hfffe, 4'h0},
      {2'd0, 7'h14, 16'hffff, 16'h0002, 16'h0001, 4'h0},
      {2'd0, 7'h15, 16'hffff, 16'h0002, 16'hffff, 4'h0},
      {2'd0, 7'h13, 16'h0000, 16'h0000, 16'hffff, 4'h0},
      {2'd0, 7'h23, 16'h0000, 16'h0000, 16'h0000, 4'h0},
      {2'd1, 7'h02, 16'h0001, 16'h0000, 16'h0000, 4'h0},
      {2'd0, 7'h08, 16'h0000, 16'h0007, 16'h2492, 4'h0},
      {2'd0, 7'h33, 16'h0000, 16'h0000, 16'h0000, 4'h0},
      {2'd0, 7'h23, 16'h0000, 16'h0000, 16'h0002, 4'h0},
      {2'd1, 7'h02, 16'hffff, 16'hfff9, 16'h0000, 4'h0},
      {2'd0, 7'h29, 16'h0000, 16'h0002, 16'hffff, 4'h0},
      {2'd0, 7'h03, 16'h0000, 16'h0000, 16'hfffd, 4'h0},
      {2'd0, 7'h13, 16'h0000, 16'h0000, 16'hffff, 4'h0},
      {2'd1, 7'h02, 16'h7fff, 16'hffff, 16'h0000, 4'h0},
      {2'd0, 7'h07, 16'h0001, 16'h0001, 16'h0000, FLAGS_OVF},
      {2'd0, 7'h03, 16'h0000, 16'h0000, 16'h0000, FLAGS_OVF},
      {2'd1, 7'h02, 16'h0000, 16'h0005, 16'h0000, 4'h0},
      {2'd0, 7'h16, 16'hffff, 16'hffff, 16'hfffe, 4'h0},
      {2'd2, 7'h00, 16'h0000, 16'h0000, 16'h0000, 4'h0},
      {2'd0, 7'h03, 16'h0000, 16'h0000, 16'h0000, 4'h0},
      {2'd0, 7'h23, 16'h0000, 16'h0000, 16'h0000, 4'h0},
      {2'd1, 7'h01, 16'habcd, 16'h1234, 16'h0000, 4'h0},
      {2'd0, 7'h13, 16'h0000, 16'h0000, 16'h0000, 4'h0},
      {2'd0, 7'h03, 16'h0000, 16'h0000, 16'h1234, 4'h0},
      {2'd1, 7'h0a, 16'h5678, 16'h9abc, 16'h0000, 4'h0},
      {2'd0, 7'h0b, 16'h0001, 16'h0001, 16'h1234, 4'h0},
      {2'd0, 7'h33, 16'h0000, 16'h0000, 16'h5678, 4'h0},
      {2'd0, 7'h23, 16'h0000, 16'h0000, 16'h9abc, 4'h0},
      {2'd0, 7'h43, 16'h0000, 16'h0000, 16'h0000, 4'h0}};
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    foreach (rows[i]) begin
      u_core.put_mode(rows[i].mode);
      if (rows[i].kind == 2'd1) begin
        u_core.put_load(rows[i].a, rows[i].b);
        @(negedge clk_i);
        check({12'h000, rsp_o.flags}, 16'h0000);
      end else if (rows[i].kind == 2'd0) begin
        u_core.put_op(rows[i].a, rows[i].b, d, f, cyc, bcnt);
        check(d, rows[i].d);
        check({12'h000, f}, {12'h000, rows[i].f});
        if (rows[i].mode[3:1] == 3'b100)
          check(16'(bcnt >= 17 && bcnt <= 20), 16'h0001);
        else
          check(16'(cyc), 16'h0001);
      end
    end
    // Load in read mode keeps a raised overflow
    u_core.put_mode(7'h02);
    u_core.put_load(16'h7fff, 16'hffff);
    u_core.put_mode(7'h17);
    u_core.put_op(16'h0001, 16'h0001, d, f, cyc, bcnt);
    check(d, 16'h8000);
    check({12'h000, f}, {12'h000, FLAGS_OVF});
    u_core.put_mode(7'h03);
    u_core.put_load(16'h0000, 16'h0000);
    @(negedge clk_i);
    check({12'h000, rsp_o.flags}, {12'h000, FLAGS_OVF});
    // Second reset in mid-run, over nonzero data and flags
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(negedge clk_i);
    check({14'h0000, busy_o, done_o}, 16'h0000);
    check(rsp_o.data, 16'h0000);
    check({12'h000, rsp_o.flags}, 16'h0000);
    u_core.put_op(16'h0003, 16'h0003, d, f, cyc, bcnt);
    check(d, 16'h0000);
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    tally_and_finish();
  end
endmodule
